// *** verilog/bslg_pkg.sv ***
// Purpose: shared constants for the boot section lock guard
// Assumes: one 20 MHz clock, AHB-Lite register access
// Notes: lock pairs are {upper,lower}, 1 = unprogrammed
package bslg_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] BSLG_OFS_LOCK = 8'h00;
    localparam logic [7:0] BSLG_OFS_CTRL = 8'h04;
    localparam logic [7:0] BSLG_OFS_BOUND = 8'h08;
    localparam logic [7:0] BSLG_OFS_STAT = 8'h0C;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BSLG_LK_APP_LO = 0;
    localparam int BSLG_LK_APP_HI = 1;
    localparam int BSLG_LK_BOOT_LO = 2;
    localparam int BSLG_LK_BOOT_HI = 3;
    localparam int BSLG_CT_VEC_BOOT = 0;
    localparam int BSLG_ST_IRQ_MASK = 0;
    localparam int BSLG_ST_PC_BOOT = 1;
    localparam int BSLG_ST_ST_REF = 2;
    localparam int BSLG_ST_LD_REF = 3;
    // ************************************************************
    // reset values, blank word for refused loads, htrans NONSEQ code
    // ************************************************************
    localparam logic [3:0] BSLG_LOCK_ERASED = 4'hF;
    localparam logic [14:0] BSLG_BOUND_RST = 15'h7000;
    localparam logic [15:0] BSLG_LOAD_BLANK = 16'hFFFF;
    localparam logic [1:0] BSLG_HTRANS_NONSEQ = 2'h2;
endpackage

// *** verilog/bslg_lock_dec.sv ***
// Purpose: decode one two-bit section lock pair
// Assumes: pair bits are 1 when unprogrammed
// Notes: mode 1=11, 2=10, 3=00, 4=01
`timescale 1ns/1ps
module bslg_lock_dec
    import bslg_pkg::*;
(
    input wire logic lock_upper,
    input wire logic lock_lower,
    output logic store_block,
    output logic cross_load_block
);
    // ************************************************************
    // pair decode
    // ************************************************************
    // lower bit programmed blocks stores (modes 2, 3)
    assign store_block = ~lock_lower;
    // upper bit programmed blocks cross loads and irqs (modes 3, 4)
    assign cross_load_block = ~lock_upper;
endmodule // bslg_lock_dec

// *** verilog/bslg_sect_class.sv ***
// Purpose: classify a word address as application or boot section
// Assumes: boot section runs from the boundary to the top of flash
// Notes: purely combinational
`timescale 1ns/1ps
module bslg_sect_class
    import bslg_pkg::*;
#(
    parameter int AW = 15
)
(
    input wire logic [AW-1:0] addr,
    input wire logic [AW-1:0] boot_start,
    output logic in_boot
);
    // ************************************************************
    // boundary compare
    // ************************************************************
    assign in_boot = (addr >= boot_start);
endmodule // bslg_sect_class

// *** verilog/bslg_guard.sv ***
// Purpose: boot/application section lock guard for program flash
// Assumes: core requests are synchronous to clk_sys, one per cycle
// Notes: registers over AHB-Lite, zero wait states while ce is high
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Two independent lock pairs: one for application, one for boot section.
// - Locks programmed by software or programming path; only chip erase clears. Here sys_rst also reloads the fuse image, dropping programmed bits.
// - General write lock never blocks stores; only section locks do.
// - General read/write lock never blocks core loads or stores.
// - Lock bit 1 means unprogrammed, 0 means programmed.
// - Application mode 1: loads and stores unrestricted.
// - Application mode 2: stores to application refused, loads allowed.
// - Application mode 3: stores refused, boot-code loads of application refused.
// - Application mode 4: only boot-code loads of application refused.
// - Application modes 3,4, vectors in boot: mask irqs in application.
// - Boot mode 1: loads and stores unrestricted.
// - Boot mode 2: stores to boot section refused, loads allowed.
// - Boot mode 3: stores refused, application-code loads of boot refused.
// - Boot mode 4: only application-code loads of boot refused.
// - Boot modes 3,4, vectors in application: mask irqs in boot.
module bslg_guard
    import bslg_pkg::*;
#(
    parameter int AW = 15,
    parameter int DW = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fuse storage and programming path
    input wire logic [3:0] fuse_lock_bits,
    input wire logic prog_lock_wr,
    input wire logic [3:0] prog_lock_data,
    input wire logic chip_erase,
    // core requests
    input wire logic req_valid,
    input wire logic req_store,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    input wire logic [AW-1:0] pc_addr,
    input wire logic [DW-1:0] flash_rdata,
    output logic req_allow,
    output logic flash_we_r,
    output logic [AW-1:0] flash_waddr_r,
    output logic [DW-1:0] flash_wdata_r,
    output logic load_valid_r,
    output logic [DW-1:0] load_data_r,
    output logic refused_r,
    output logic irq_mask_r
);
    // ************************************************************
    // elaboration checks
    // ************************************************************
    // boundary reset value is 15 bits wide, so wider addresses cannot fit
    if (AW < 1 || AW > 15) begin : g_aw_chk
        $error("address width must be 1..15");
    end
    if (DW < 1 || DW > 16) begin : g_dw_chk
        $error("data width must be 1..16");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic [3:0] lock_r, lock_nxt;
    logic fuse_pend_r, fuse_pend_nxt;
    logic vec_boot_r, vec_boot_nxt;
    logic [AW-1:0] bound_r, bound_nxt;
    logic st_ref_r, st_ref_nxt;
    logic ld_ref_r, ld_ref_nxt;
    logic dp_wr_r, dp_wr_nxt;
    logic [7:0] dp_addr_r, dp_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic flash_we_nxt;
    logic [AW-1:0] flash_waddr_nxt;
    logic [DW-1:0] flash_wdata_nxt;
    logic load_valid_nxt;
    logic [DW-1:0] load_data_nxt;
    logic refused_nxt;
    logic irq_mask_nxt;
    logic app_st_blk, app_x_blk, boot_st_blk, boot_x_blk;
    logic tgt_boot, pc_boot;
    logic ap_take, sw_lock_wr, st_clr, ld_clr;
    logic store_ok, load_ok, st_refuse, ld_refuse;

    // ************************************************************
    // lock decode and section classification
    // ************************************************************
    // one decoder per section, each fed only by its own pair
    bslg_lock_dec u_app_dec (
        .lock_upper(lock_r[BSLG_LK_APP_HI]),
        .lock_lower(lock_r[BSLG_LK_APP_LO]),
        .store_block(app_st_blk),
        .cross_load_block(app_x_blk)
    );
    bslg_lock_dec u_boot_dec (
        .lock_upper(lock_r[BSLG_LK_BOOT_HI]),
        .lock_lower(lock_r[BSLG_LK_BOOT_LO]),
        .store_block(boot_st_blk),
        .cross_load_block(boot_x_blk)
    );
    bslg_sect_class #(.AW(AW)) u_tgt_cls (
        .addr(req_addr),
        .boot_start(bound_r),
        .in_boot(tgt_boot)
    );
    bslg_sect_class #(.AW(AW)) u_pc_cls (
        .addr(pc_addr),
        .boot_start(bound_r),
        .in_boot(pc_boot)
    );

    // ************************************************************
    // access permission
    // ************************************************************
    // only section locks are consulted; general locks have no say
    always_comb begin
        // stores: mode 1 or 4 of the target section passes
        store_ok = tgt_boot ? ~boot_st_blk : ~app_st_blk;
        // loads: refused only across sections in modes 3, 4
        if (tgt_boot) begin
            load_ok = pc_boot | ~boot_x_blk;
        end else begin
            load_ok = ~pc_boot | ~app_x_blk;
        end
        req_allow = req_store ? store_ok : load_ok;
        st_refuse = req_valid & req_store & ~store_ok;
        ld_refuse = req_valid & ~req_store & ~load_ok;
    end

    // ************************************************************
    // flash side next values
    // ************************************************************
    always_comb begin
        flash_we_nxt = 1'b0;
        flash_waddr_nxt = flash_waddr_r;
        flash_wdata_nxt = flash_wdata_r;
        load_valid_nxt = 1'b0;
        load_data_nxt = load_data_r;
        refused_nxt = st_refuse | ld_refuse;
        if (req_valid && req_store && store_ok) begin
            flash_we_nxt = 1'b1;
            flash_waddr_nxt = req_addr;
            flash_wdata_nxt = req_wdata;
        end
        if (req_valid && !req_store) begin
            load_valid_nxt = 1'b1;
            // protected words never leave the guard
            load_data_nxt = load_ok ? flash_rdata : BSLG_LOAD_BLANK[DW-1:0];
        end
        // interrupt masking while running in the locked-down section
        irq_mask_nxt = (app_x_blk & vec_boot_r & ~pc_boot)
            | (boot_x_blk & ~vec_boot_r & pc_boot);
    end

    // ************************************************************
    // lock bit next value
    // ************************************************************
    assign ap_take = hsel & hready & htrans[1];
    assign sw_lock_wr = dp_wr_r & (dp_addr_r == BSLG_OFS_LOCK);
    always_comb begin
        lock_nxt = lock_r;
        fuse_pend_nxt = 1'b0;
        if (chip_erase) begin
            lock_nxt = BSLG_LOCK_ERASED;
        end else begin
            if (fuse_pend_r) begin
                // fuse image caught once after reset release
                lock_nxt = fuse_lock_bits;
            end
            // writing 0 programs a bit; writing 1 leaves it
            if (sw_lock_wr) begin
                lock_nxt = lock_nxt & hwdata[3:0];
            end
            if (prog_lock_wr) begin
                lock_nxt = lock_nxt & prog_lock_data;
            end
        end
    end

    // ************************************************************
    // register file next values
    // ************************************************************
    always_comb begin
        vec_boot_nxt = vec_boot_r;
        bound_nxt = bound_r;
        st_clr = 1'b0;
        ld_clr = 1'b0;
        dp_wr_nxt = 1'b0;
        dp_addr_nxt = dp_addr_r;
        hrdata_nxt = hrdata_r;
        if (dp_wr_r) begin
            case (dp_addr_r)
                BSLG_OFS_CTRL: vec_boot_nxt = hwdata[BSLG_CT_VEC_BOOT];
                BSLG_OFS_BOUND: bound_nxt = hwdata[AW-1:0];
                BSLG_OFS_STAT: begin
                    st_clr = hwdata[BSLG_ST_ST_REF];
                    ld_clr = hwdata[BSLG_ST_LD_REF];
                end
                default: ;
            endcase
        end
        // a refusal in the clear cycle survives
        st_ref_nxt = st_refuse | (st_ref_r & ~st_clr);
        ld_ref_nxt = ld_refuse | (ld_ref_r & ~ld_clr);
        if (ap_take) begin
            dp_wr_nxt = hwrite;
            dp_addr_nxt = {haddr[7:2], 2'b00};
            hrdata_nxt = 32'h0000_0000;
            if (!hwrite) begin
                case ({haddr[7:2], 2'b00})
                    BSLG_OFS_LOCK: hrdata_nxt[3:0] = lock_r;
                    BSLG_OFS_CTRL:
                        hrdata_nxt[BSLG_CT_VEC_BOOT] = vec_boot_r;
                    BSLG_OFS_BOUND: hrdata_nxt[AW-1:0] = bound_r;
                    BSLG_OFS_STAT: begin
                        hrdata_nxt[BSLG_ST_IRQ_MASK] = irq_mask_r;
                        hrdata_nxt[BSLG_ST_PC_BOOT] = pc_boot;
                        hrdata_nxt[BSLG_ST_ST_REF] = st_ref_r;
                        hrdata_nxt[BSLG_ST_LD_REF] = ld_ref_r;
                    end
                    default: hrdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // bus outputs
    // ************************************************************
    // ce low stretches the data phase so no access is lost
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lock_r <= BSLG_LOCK_ERASED;
            fuse_pend_r <= 1'b1;
            vec_boot_r <= 1'b0;
            bound_r <= BSLG_BOUND_RST[AW-1:0];
            st_ref_r <= 1'b0;
            ld_ref_r <= 1'b0;
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            flash_we_r <= 1'b0;
            flash_waddr_r <= '0;
            flash_wdata_r <= '0;
            load_valid_r <= 1'b0;
            load_data_r <= '0;
            refused_r <= 1'b0;
            irq_mask_r <= 1'b0;
        end else if (ce) begin
            lock_r <= lock_nxt;
            fuse_pend_r <= fuse_pend_nxt;
            vec_boot_r <= vec_boot_nxt;
            bound_r <= bound_nxt;
            st_ref_r <= st_ref_nxt;
            ld_ref_r <= ld_ref_nxt;
            dp_wr_r <= dp_wr_nxt;
            dp_addr_r <= dp_addr_nxt;
            hrdata_r <= hrdata_nxt;
            flash_we_r <= flash_we_nxt;
            flash_waddr_r <= flash_waddr_nxt;
            flash_wdata_r <= flash_wdata_nxt;
            load_valid_r <= load_valid_nxt;
            load_data_r <= load_data_nxt;
            refused_r <= refused_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_APP_STORE_BLOCK: assert property (
        ce && req_valid && req_store && !tgt_boot
            && !lock_r[BSLG_LK_APP_LO] |=> !flash_we_r && refused_r)
        else $error("store into locked application went through");
    AST_BOOT_STORE_BLOCK: assert property (
        ce && req_valid && req_store && tgt_boot
            && !lock_r[BSLG_LK_BOOT_LO] |=> !flash_we_r && refused_r)
        else $error("store into locked boot section went through");
    AST_STORE_FREE: assert property (
        ce && req_valid && req_store && lock_r == BSLG_LOCK_ERASED
        |=> flash_we_r && flash_waddr_r == $past(req_addr))
        else $error("store refused with no lock programmed");
    AST_APP_XLOAD: assert property (
        ce && req_valid && !req_store && !tgt_boot && pc_boot
            && !lock_r[BSLG_LK_APP_HI]
        |=> load_valid_r && load_data_r == BSLG_LOAD_BLANK[DW-1:0])
        else $error("boot code read protected application data");
    AST_BOOT_XLOAD: assert property (
        ce && req_valid && !req_store && tgt_boot && !pc_boot
            && !lock_r[BSLG_LK_BOOT_HI] |=> refused_r)
        else $error("application code read protected boot data");
    AST_SAME_LOAD: assert property (
        ce && req_valid && !req_store && tgt_boot == pc_boot
        |=> load_valid_r && !refused_r
            && load_data_r == $past(flash_rdata))
        else $error("own-section load was refused");
    AST_IRQ_APP: assert property (
        ce && !lock_r[BSLG_LK_APP_HI] && vec_boot_r && !pc_boot
        |=> irq_mask_r)
        else $error("irqs not masked in application");
    AST_IRQ_BOOT: assert property (
        ce && !lock_r[BSLG_LK_BOOT_HI] && !vec_boot_r && pc_boot
        |=> irq_mask_r)
        else $error("irqs not masked in boot section");
    AST_ERASE: assert property (
        ce && chip_erase |=> lock_r == BSLG_LOCK_ERASED)
        else $error("chip erase did not clear lock bits");
    AST_NO_UNPROG: assert property (
        ce && !chip_erase && !fuse_pend_r
        |=> (lock_r & ~$past(lock_r)) == 4'h0)
        else $error("lock bit returned to 1 without erase");
    AST_FREEZE: assert property (
        !ce |=> $stable(lock_r) && $stable(hrdata_r))
        else $error("state moved while ce low");

    COV_STORE_REFUSED: cover property (ce && st_refuse);
    COV_LOAD_REFUSED: cover property (ce && ld_refuse);
    COV_IRQ_MASK: cover property (irq_mask_r ##1 !irq_mask_r);
    COV_SW_LOCK: cover property (ce && sw_lock_wr);
endmodule // bslg_guard

// *** test/bslg_core_model.sv ***
// Purpose: core and flash stand-in facing the lock guard
// Assumes: one request per cycle, signals changed after rising edge
// Notes: 16-word flash image indexed by the low address bits
`timescale 1ns/1ps
module bslg_core_model
    import bslg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic req_allow,
    output logic req_valid,
    output logic req_store,
    output logic [14:0] req_addr,
    output logic [15:0] req_wdata,
    output logic [14:0] pc_addr,
    output logic [15:0] flash_rdata,
    input wire logic flash_we_r,
    input wire logic [14:0] flash_waddr_r,
    input wire logic [15:0] flash_wdata_r
);
    logic [15:0] mem [16];

    // ************************************************************
    // flash image and idle core
    // ************************************************************
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {12'hA5A, 4'(i)};
        end
        req_valid = 1'h0;
        req_store = 1'h0;
        req_addr = 15'h0000;
        req_wdata = 16'h0000;
        pc_addr = 15'h0000;
    end

    // only granted stores ever reach the array
    always @(posedge clk_sys) begin
        if (flash_we_r === 1'h1) begin
            mem[flash_waddr_r[3:0]] <= flash_wdata_r;
        end
    end

    // flash answers in the request cycle
    assign flash_rdata = mem[req_addr[3:0]];

    // one-cycle request, allow sampled mid-cycle
    task automatic issue(input logic st, input logic [14:0] a,
                         input logic [15:0] d, output logic allow);
        @(posedge clk_sys);
        req_valid <= 1'h1;
        req_store <= st;
        req_addr <= a;
        req_wdata <= d;
        @(negedge clk_sys);
        allow = req_allow;
        @(posedge clk_sys);
        req_valid <= 1'h0;
    endtask

    // move the program counter
    task automatic set_pc(input logic [14:0] p);
        @(posedge clk_sys);
        pc_addr <= p;
    endtask
endmodule // bslg_core_model

// *** test/bslg_guard_tb.sv ***
// Purpose: self-checking bench for the section lock guard
// Assumes: ce high except in the freeze case, no bus access while low
// Notes: lock table rows, then lock, freeze, boundary and reset cases
`timescale 1ns/1ps
module bslg_guard_tb;
    import bslg_pkg::*;
    typedef struct packed {
        logic [3:0] lk;
        logic vb;
        logic st;
        logic [14:0] a;
        logic [14:0] pc;
        logic ok;
        logic irq;
    } bslg_row_t;
    localparam logic [14:0] AS = 15'h0101;
    localparam logic [14:0] AL = 15'h0104;
    localparam logic [14:0] BS = 15'h7102;
    localparam logic [14:0] BL = 15'h7108;
    localparam logic [14:0] PA = 15'h0010;
    localparam logic [14:0] PB = 15'h7010;
    logic clk_sys, sys_rst, ce, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [3:0] fuse_lock_bits, prog_lock_data;
    logic prog_lock_wr, chip_erase, req_valid, req_store, req_allow;
    logic [14:0] req_addr, pc_addr, flash_waddr_r;
    logic [15:0] req_wdata, flash_rdata, flash_wdata_r, load_data_r;
    logic flash_we_r, load_valid_r, refused_r, irq_mask_r;
    int failures = 0;
    int num_checks = 0;
    bslg_row_t rows [16];
    logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] rexp [5] = '{32'h6, 32'h0, 32'h7000, 32'h0, 32'h0};

    // ************************************************************
    // design, core model and clock
    // ************************************************************
    bslg_guard dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fuse_lock_bits(fuse_lock_bits), .prog_lock_wr(prog_lock_wr),
        .prog_lock_data(prog_lock_data), .chip_erase(chip_erase),
        .req_valid(req_valid), .req_store(req_store), .req_addr(req_addr),
        .req_wdata(req_wdata), .pc_addr(pc_addr), .flash_rdata(flash_rdata),
        .req_allow(req_allow), .flash_we_r(flash_we_r),
        .flash_waddr_r(flash_waddr_r), .flash_wdata_r(flash_wdata_r),
        .load_valid_r(load_valid_r), .load_data_r(load_data_r),
        .refused_r(refused_r), .irq_mask_r(irq_mask_r));
    bslg_core_model u_core (.clk_sys(clk_sys), .req_allow(req_allow),
        .req_valid(req_valid), .req_store(req_store), .req_addr(req_addr),
        .req_wdata(req_wdata), .pc_addr(pc_addr), .flash_rdata(flash_rdata),
        .flash_we_r(flash_we_r), .flash_waddr_r(flash_waddr_r),
        .flash_wdata_r(flash_wdata_r));
    always #25 clk_sys = ~clk_sys;

    // ************************************************************
    // helper tasks
    // ************************************************************
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic ahb_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (hreadyout !== 1'h1) begin
            failures++;
            end_of_test();
        end
    endtask

    // single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        htrans <= BSLG_HTRANS_NONSEQ;
        hwrite <= wr;
        ahb_wait();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        ahb_wait();
        r = hrdata;
        check(32'(hresp), 32'h0);
    endtask

    task automatic prog(input logic [3:0] d);
        @(posedge clk_sys);
        prog_lock_wr <= 1'h1;
        prog_lock_data <= d;
        @(posedge clk_sys);
        prog_lock_wr <= 1'h0;
    endtask

    // erase back to unprogrammed, then program the wanted pair bits
    task automatic set_lock(input logic [3:0] d);
        @(posedge clk_sys);
        chip_erase <= 1'h1;
        @(posedge clk_sys);
        chip_erase <= 1'h0;
        prog(d);
    endtask

    // one core request and its one-cycle answer
    task automatic req_check(input logic st, input logic [14:0] a,
                             input logic ok);
        logic al;
        logic [15:0] d, old;
        d = {1'h0, a} ^ 16'h3C3C;
        old = u_core.mem[a[3:0]];
        u_core.issue(st, a, d, al);
        @(negedge clk_sys);
        check(32'(al), 32'(ok));
        check(32'(refused_r), 32'(!ok));
        if (st) begin
            check(32'(flash_we_r), 32'(ok));
            if (ok) begin
                check(32'({flash_waddr_r, flash_wdata_r}), 32'({a, d}));
            end else begin
                @(negedge clk_sys);
                check(32'(u_core.mem[a[3:0]]), 32'(old));
            end
        end else begin
            check(32'(load_valid_r), 32'h1);
            check(32'(load_data_r),
                  ok ? {20'h00A5A, a[3:0]} : 32'(BSLG_LOAD_BLANK));
        end
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rows = '{'{4'hF, 1'h1, 1'h1, AS, PA, 1'h1, 1'h0},
                 '{4'hE, 1'h1, 1'h1, AS, PB, 1'h0, 1'h0},
                 '{4'hE, 1'h1, 1'h0, AL, PB, 1'h1, 1'h0},
                 '{4'hC, 1'h1, 1'h1, AS, PB, 1'h0, 1'h0},
                 '{4'hC, 1'h1, 1'h0, AL, PB, 1'h0, 1'h0},
                 '{4'hC, 1'h1, 1'h0, AL, PA, 1'h1, 1'h1},
                 '{4'hD, 1'h1, 1'h1, AS, PA, 1'h1, 1'h1},
                 '{4'hD, 1'h0, 1'h0, AL, PB, 1'h0, 1'h0},
                 '{4'hB, 1'h0, 1'h1, BS, PA, 1'h0, 1'h0},
                 '{4'hB, 1'h0, 1'h0, BL, PA, 1'h1, 1'h0},
                 '{4'h3, 1'h0, 1'h1, BS, PB, 1'h0, 1'h1},
                 '{4'h3, 1'h0, 1'h0, BL, PA, 1'h0, 1'h0},
                 '{4'h3, 1'h0, 1'h0, BL, PB, 1'h1, 1'h1},
                 '{4'h7, 1'h1, 1'h1, BS, PA, 1'h1, 1'h0},
                 '{4'hC, 1'h1, 1'h1, BS, PA, 1'h1, 1'h1},
                 '{4'h7, 1'h1, 1'h0, BL, PA, 1'h0, 1'h0}};
        clk_sys = 1'h0;
        ce = 1'h1;
        sys_rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        fuse_lock_bits = 4'h6;
        prog_lock_wr = 1'h0;
        prog_lock_data = 4'hF;
        chip_erase = 1'h0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        // register reset values and fuse capture
        for (int i = 0; i < 5; i++) begin
            ahb(1'h0, offs[i], 32'h0, rd);
            check(rd, rexp[i]);
        end
        // lock table
        for (int i = 0; i < 16; i++) begin
            set_lock(rows[i].lk);
            ahb(1'h1, BSLG_OFS_CTRL, 32'(rows[i].vb), rd);
            u_core.set_pc(rows[i].pc);
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            check(32'(irq_mask_r), 32'(rows[i].irq));
            req_check(rows[i].st, rows[i].a, rows[i].ok);
        end
        // locks only program, erase alone restores
        set_lock(4'hE);
        prog(4'hD);
        ahb(1'h1, BSLG_OFS_LOCK, 32'hF, rd);
        ahb(1'h0, BSLG_OFS_LOCK, 32'h0, rd);
        check(rd, 32'hC);
        ahb(1'h1, BSLG_OFS_LOCK, 32'h7, rd);
        ahb(1'h0, BSLG_OFS_LOCK, 32'h0, rd);
        check(rd, 32'h4);
        set_lock(4'hF);
        ahb(1'h0, BSLG_OFS_LOCK, 32'h0, rd);
        check(rd, 32'hF);
        // ce low: a programming strobe must not reach the locks
        ce <= 1'h0;
        prog(4'h0);
        @(posedge clk_sys);
        ce <= 1'h1;
        ahb(1'h0, BSLG_OFS_LOCK, 32'h0, rd);
        check(rd, 32'hF);
        // moved boundary, edge addresses, sticky refusal flag
        set_lock(4'hB);
        ahb(1'h1, BSLG_OFS_BOUND, 32'h0200, rd);
        ahb(1'h1, BSLG_OFS_STAT, 32'hC, rd);
        req_check(1'h1, 15'h01FF, 1'h1);
        req_check(1'h1, 15'h0200, 1'h0);
        ahb(1'h0, BSLG_OFS_STAT, 32'h0, rd);
        check(rd & 32'hC, 32'h4);
        ahb(1'h1, BSLG_OFS_STAT, 32'hC, rd);
        ahb(1'h0, BSLG_OFS_STAT, 32'h0, rd);
        check(rd & 32'hC, 32'h0);
        // mid-run reset: registers back, fuse image taken again
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        check(32'(load_data_r), 32'h0);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        ahb(1'h0, BSLG_OFS_BOUND, 32'h0, rd);
        check(rd, 32'h7000);
        ahb(1'h0, BSLG_OFS_LOCK, 32'h0, rd);
        check(rd, 32'h6);
        end_of_test();
    end
endmodule // bslg_guard_tb
